// >>> logic/dmac_pkg.sv
package dmac_pkg;
  // Register select codes of a received byte
  localparam logic [1:0] DMAC_RS_CMD = 2'h0;
  localparam logic [1:0] DMAC_RS_DATA = 2'h1;
  localparam logic [1:0] DMAC_RS_DISP = 2'h2;
  // Display control command bytes
  localparam logic [7:0] DMAC_CMD_CLEAR = 8'h00;
  localparam logic [7:0] DMAC_CMD_HOME = 8'h01;
  localparam logic [5:0] DMAC_ENTRY_TAG = 6'h0A;
  localparam int DMAC_ENTRY_DIR_BIT = 1;
  localparam int DMAC_ENTRY_SHIFT_BIT = 0;
  // Memory setup commands on select code 00
  localparam logic [4:0] DMAC_BANK_TAG = 5'h02;
  localparam int DMAC_ADDR_LOAD_BIT = 7;
  // Memory bank choice encodings
  localparam logic [2:0] DMAC_BANK_TEXT = 3'h0;
  localparam logic [2:0] DMAC_BANK_GLY0 = 3'h1;
  localparam logic [2:0] DMAC_BANK_GLY2 = 3'h3;
  localparam logic [2:0] DMAC_BANK_ICON = 3'h4;
  localparam logic [2:0] DMAC_BANK_FIXED = 3'h5;
  // Sizes
  localparam int DMAC_AW = 7;
  localparam int DMAC_TXT_DEPTH = 80;
  localparam int DMAC_ICON_DEPTH = 80;
  localparam int DMAC_GLY_COLS = 3;
  localparam int DMAC_GLY_DEPTH = 128;
  localparam int DMAC_NARROW_W = 5;
  // Values
  localparam logic [7:0] DMAC_BLANK_CHAR = 8'h20;
  localparam logic [6:0] DMAC_ADDR_RST = 7'h00;
  localparam logic [6:0] DMAC_SHIFT_RST = 7'h00;
  localparam logic [6:0] DMAC_SHIFT_LAST = 7'h4F;
  localparam logic [2:0] DMAC_BANK_RST = 3'h0;
  localparam logic DMAC_DIR_RST = 1'b1;
  localparam logic DMAC_SHIFT_EN_RST = 1'b0;
endpackage

// >>> logic/dmac_core.sv
// Operation
// - Read with select 01 returns addressed byte
// - Writable glyph and icon reads zero-pad bits 7..5
// - Reads follow the selected memory bank
// - Address counter steps by one after reads
// - Write with select 01 stores byte or low five
// - Writes reach only writable banks, never fixed
// - Address counter steps by one after writes
// - Clear fills every text address with 20h
// - Clear keeps address counter and step direction
// - Home zeroes address and display shift
// - Home keeps direction and shift setting
// - Entry mode sets direction and shift enable
// - Direction one increments, zero decrements address
// - Text writes shift display when enabled
// - Reads and glyph or icon writes never shift
// - Three-bit bank choice with fixed encodings
// - Seven-bit address counter, loadable, resets zero
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module dmac_core
  import dmac_pkg::*;
(
  input wire logic sys_clk_i, // 10 MHz clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic [1:0] bus_rs_i, // Register select code of the byte
  input wire logic [7:0] bus_wdata_i, // Byte from the host
  input wire logic bus_wr_i, // Write strobe, read_not_write 0
  input wire logic bus_rd_i, // Read strobe, read_not_write 1
  input wire logic [7:0] rom_data_i, // Fixed glyph byte at rom_addr_o
  output logic [7:0] bus_rdata_o, // Read data, cycle after read strobe
  output logic [6:0] addr_o, // Address counter, also cursor position
  output logic [6:0] rom_addr_o, // Address into fixed glyph memory
  output logic [2:0] bank_o, // Memory bank choice
  output logic step_dir_o, // Step direction, 1 increments
  output logic shift_en_o, // Display shift setting
  output logic [6:0] shift_ofs_o, // Current display shift offset
  output logic [1:0] last_rs_o, // Select code of last byte
  output logic last_rnw_o // Direction of last byte
);

  // Next address after one data access; wraps modulo 128 at both ends
  // Steps even for refused writes, so the cursor stays predictable
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up);
    step_addr = up ? a + 7'h01 : a - 7'h01;
  endfunction

  // Bank holds five-bit cells
  function automatic logic is_narrow(input logic [2:0] b);
    is_narrow = (b == DMAC_BANK_ICON) || (b >= DMAC_BANK_GLY0 && b <= DMAC_BANK_GLY2);
  endfunction

  // Control state
  logic [6:0] addr_q; // Address counter
  logic [2:0] bank_q; // Memory bank choice
  logic dir_q; // Step direction
  logic shift_en_q; // Shift setting
  logic [6:0] shift_q; // Display shift offset
  logic [7:0] rdata_q; // Registered read data
  logic [1:0] rs_q; // Latched select code
  logic rnw_q; // Latched direction

  // Storage
  logic [7:0] text_q [DMAC_TXT_DEPTH]; // Display text memory
  logic [4:0] icon_q [DMAC_ICON_DEPTH]; // Icon pixel memory
  logic [4:0] glyph_q [DMAC_GLY_COLS][DMAC_GLY_DEPTH]; // Writable glyph memory

  // Byte classification
  wire logic data_rd = bus_rd_i && bus_rs_i == DMAC_RS_DATA;
  wire logic data_wr = bus_wr_i && bus_rs_i == DMAC_RS_DATA;
  wire logic disp_wr = bus_wr_i && bus_rs_i == DMAC_RS_DISP;
  wire logic cfg_wr = bus_wr_i && bus_rs_i == DMAC_RS_CMD;
  wire logic clear_cmd = disp_wr && bus_wdata_i == DMAC_CMD_CLEAR;
  wire logic home_cmd = disp_wr && bus_wdata_i == DMAC_CMD_HOME;
  wire logic entry_cmd = disp_wr && bus_wdata_i[7:2] == DMAC_ENTRY_TAG;
  wire logic addr_cmd = cfg_wr && bus_wdata_i[DMAC_ADDR_LOAD_BIT];
  wire logic bank_cmd = cfg_wr && bus_wdata_i[7:3] == DMAC_BANK_TAG;

  // Bank decode
  wire logic sel_text = bank_q == DMAC_BANK_TEXT;
  wire logic sel_icon = bank_q == DMAC_BANK_ICON;
  wire logic sel_fixed = bank_q == DMAC_BANK_FIXED;
  wire logic sel_glyph = is_narrow(bank_q) && !sel_icon;
  wire logic [1:0] gly_col = 2'(bank_q - DMAC_BANK_GLY0);
  // Text and icon cells end at 79; higher addresses hold nothing
  wire logic txt_hit = addr_q < 7'(DMAC_TXT_DEPTH);
  wire logic icon_hit = addr_q < 7'(DMAC_ICON_DEPTH);

  // Write enables; the fixed bank and unused codes take no data
  wire logic txt_we = data_wr && sel_text && txt_hit;
  wire logic icon_we = data_wr && sel_icon && icon_hit;
  wire logic gly_we = data_wr && sel_glyph;
  wire logic [4:0] narrow_wd = bus_wdata_i[4:0];

  // Shift on text writes only, direction opposite to stepping
  wire logic shift_now = data_wr && sel_text && shift_en_q;
  wire logic [6:0] shift_left =
    (shift_q == DMAC_SHIFT_LAST) ? DMAC_SHIFT_RST : shift_q + 7'h01;
  wire logic [6:0] shift_right =
    (shift_q == DMAC_SHIFT_RST) ? DMAC_SHIFT_LAST : shift_q - 7'h01;

  // Read selection across banks
  wire logic [7:0] txt_rd = txt_hit ? text_q[addr_q] : 8'h00;
  wire logic [4:0] icon_rd = icon_hit ? icon_q[addr_q] : 5'h00;
  wire logic [4:0] gly_rd = glyph_q[gly_col][addr_q];
  wire logic [7:0] rd_sel =
    sel_text ? txt_rd :
    sel_fixed ? rom_data_i :
    sel_icon ? {3'h0, icon_rd} :
    sel_glyph ? {3'h0, gly_rd} :
    8'h00;

  // Access steps, built up for the checks further down
  // Data access of either kind on select code 01
  sequence s_data_access;
    (bus_rd_i || bus_wr_i) && bus_rs_i == DMAC_RS_DATA && !addr_cmd;
  endsequence

  // Reads on setup, display or unused codes
  sequence s_ctrl_read;
    bus_rd_i && bus_rs_i != DMAC_RS_DATA;
  endsequence

  sequence s_text_write;
    data_wr && bank_q == DMAC_BANK_TEXT && shift_en_q;
  endsequence

  // Text write with shift on, split by stepping direction
  sequence s_shift_left;
    s_text_write ##0 dir_q;
  endsequence

  sequence s_shift_right;
    s_text_write ##0 !dir_q;
  endsequence

  // Latch select code and direction of each byte seen
  // Observation only; decoding acts on the strobe cycle itself
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rs_q <= DMAC_RS_CMD;
      rnw_q <= 1'b0;
    end else if (bus_wr_i || bus_rd_i) begin
      rs_q <= bus_rs_i;
      rnw_q <= bus_rd_i;
    end
  end

  // Read data stands for one cycle only
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= data_rd ? rd_sel : 8'h00;
    end
  end

  // Nothing but a data read may drive the read bus
  rdata_idle_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !data_rd |=> bus_rdata_o == 8'h00)
    else $error("read data seen without a data read");

  // Fixed bank answers with the full byte from the glyph store
  read_fixed_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    data_rd && sel_fixed |=> bus_rdata_o == $past(rom_data_i))
    else $error("fixed glyph read lost bits");

  // Icon reads carry the stored five bits, high bits zero
  read_icon_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    data_rd && sel_icon && icon_hit |=> bus_rdata_o == {3'h0, $past(icon_q[addr_q])})
    else $error("icon read returned wrong cell");

  // Address counter: load, home, step after each data access
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      addr_q <= DMAC_ADDR_RST;
    end else if (addr_cmd) begin
      addr_q <= bus_wdata_i[6:0];
    end else if (home_cmd) begin
      addr_q <= DMAC_ADDR_RST;
    end else if (data_rd || data_wr) begin
      addr_q <= step_addr(addr_q, dir_q);
    end
  end

  // Address load takes the low seven bits as they are
  addr_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    addr_cmd |=> addr_q == $past(bus_wdata_i[6:0]))
    else $error("address load not taken");

  // A read on a command code answers zero and leaves the cursor
  ctrl_read_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_ctrl_read |=> $stable(addr_q) && bus_rdata_o == 8'h00)
    else $error("non-data read moved address or answered");

  // Entry mode; clear and home leave these alone
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      dir_q <= DMAC_DIR_RST;
      shift_en_q <= DMAC_SHIFT_EN_RST;
    end else if (entry_cmd) begin
      dir_q <= bus_wdata_i[DMAC_ENTRY_DIR_BIT];
      shift_en_q <= bus_wdata_i[DMAC_ENTRY_SHIFT_BIT];
    end
  end

  // Direction and shift setting move only on entry mode
  entry_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !entry_cmd |=> $stable(dir_q) && $stable(shift_en_q))
    else $error("entry setting changed without entry mode");

  // Bank choice; unused codes are stored but reach no memory
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bank_q <= DMAC_BANK_RST;
    end else if (bank_cmd) begin
      bank_q <= bus_wdata_i[2:0];
    end
  end

  // Bank choice follows the setup byte
  bank_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    bank_cmd |=> bank_o == $past(bus_wdata_i[2:0]))
    else $error("bank choice not taken");

  // Display shift offset wraps over the text depth
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      shift_q <= DMAC_SHIFT_RST;
    end else if (home_cmd) begin
      shift_q <= DMAC_SHIFT_RST;
    end else if (shift_now) begin
      shift_q <= dir_q ? shift_left : shift_right;
    end
  end

  // Left shift raises the offset, right shift lowers it, both wrap
  shift_left_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_shift_left |=> shift_q == (($past(shift_q) == DMAC_SHIFT_LAST) ? DMAC_SHIFT_RST : 7'($past(shift_q) + 7'h01)))
    else $error("left shift offset wrong");

  shift_right_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_shift_right |=> shift_q == (($past(shift_q) == DMAC_SHIFT_RST) ? DMAC_SHIFT_LAST : 7'($past(shift_q) - 7'h01)))
    else $error("right shift offset wrong");

  // Text memory; clear blanks every cell in one cycle
  // Wide fan-out for a one-cycle clear, so the host never waits
  always_ff @(posedge sys_clk_i) begin
    if (clear_cmd) begin
      for (int i = 0; i < DMAC_TXT_DEPTH; i++) begin
        text_q[i] <= DMAC_BLANK_CHAR;
      end
    end else if (txt_we) begin
      text_q[addr_q] <= bus_wdata_i;
    end
  end

  // A stored text byte reads back whole on the next cycle
  text_store_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    txt_we |=> text_q[$past(addr_q)] == $past(bus_wdata_i))
    else $error("text byte not stored");

  // Icon and glyph memories keep only five bits
  always_ff @(posedge sys_clk_i) begin
    if (icon_we) begin
      icon_q[addr_q] <= narrow_wd;
    end
  end

  // Icon cell keeps the low five bits of the byte
  icon_store_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    icon_we |=> icon_q[$past(addr_q)] == $past(narrow_wd))
    else $error("icon cell not stored");

  // One write port per column, picked by the bank code
  always_ff @(posedge sys_clk_i) begin
    if (gly_we) begin
      glyph_q[gly_col][addr_q] <= narrow_wd;
    end
  end

  // Glyph column cell keeps the low five bits of the byte
  glyph_store_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    gly_we |=> glyph_q[$past(gly_col)][$past(addr_q)] == $past(narrow_wd))
    else $error("glyph cell not stored");

  // Outputs straight from flops
  assign bus_rdata_o = rdata_q;
  assign addr_o = addr_q;
  assign rom_addr_o = addr_q;
  assign bank_o = bank_q;
  assign step_dir_o = dir_q;
  assign shift_en_o = shift_en_q;
  assign shift_ofs_o = shift_q;
  assign last_rs_o = rs_q;
  assign last_rnw_o = rnw_q;

  // Checks over the whole access path
  read_narrow_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    data_rd && is_narrow(bank_q) |=> bus_rdata_o[7:5] == 3'h0)
    else $error("narrow bank read has high bits set");

  read_value_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    data_rd && bank_q == DMAC_BANK_TEXT && addr_q < 7'(DMAC_TXT_DEPTH)
    |=> bus_rdata_o == $past(text_q[addr_q]))
    else $error("text read returned wrong byte");

  step_once_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_data_access |=> addr_q == ($past(dir_q) ? $past(addr_q) + 7'h01 : $past(addr_q) - 7'h01))
    else $error("address did not step by one");

  fixed_wr_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    data_wr && sel_fixed |-> !txt_we && !icon_we && !gly_we)
    else $error("write reached fixed glyph bank");

  clear_fill_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    clear_cmd |=> text_q[$past(addr_q) % DMAC_TXT_DEPTH] == DMAC_BLANK_CHAR && text_q[0] == DMAC_BLANK_CHAR)
    else $error("clear left a text cell unblanked");

  clear_keep_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    clear_cmd |=> $stable(addr_q) && $stable(dir_q))
    else $error("clear changed address or direction");

  home_reset_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    home_cmd |=> addr_q == DMAC_ADDR_RST && shift_q == DMAC_SHIFT_RST && $stable(dir_q) && $stable(shift_en_q))
    else $error("home did not reset position");

  entry_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    entry_cmd |=> dir_q == $past(bus_wdata_i[1]) && shift_en_q == $past(bus_wdata_i[0]))
    else $error("entry mode not taken");

  shift_dir_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_text_write |=> shift_q != $past(shift_q))
    else $error("text write did not shift display");

  no_shift_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (data_rd || (data_wr && !sel_text)) |=> $stable(shift_q))
    else $error("display shifted on read or narrow write");

  latch_sel_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (bus_wr_i || bus_rd_i) |=> last_rs_o == $past(bus_rs_i) && last_rnw_o == $past(bus_rd_i))
    else $error("select code not latched");

endmodule

// >>> sim/dmac_rom_model.sv
`timescale 1ns/1ps
// Fixed glyph memory, answers in the same cycle
module dmac_rom_model (
  input wire logic [6:0] rom_addr_i, // Cell address
  output logic [7:0] rom_data_o // Cell byte
);
  // Full-width pattern, distinct per cell, so bit 7..5 loss shows
  // No write path exists at all
  assign rom_data_o = {rom_addr_i, 1'b1} ^ 8'hA5;
endmodule

// >>> sim/tb_display_memory_access_control.sv
`timescale 1ns/1ps
module tb_display_memory_access_control;
  import dmac_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] rs = 2'h0; // Select code to core
  logic [7:0] wd = 8'h00; // Host byte
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rom, rdata;
  logic [6:0] addr, rom_addr, ofs;
  logic [2:0] bank;
  logic dir, sen, lrnw;
  logic [1:0] lrs;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int seed = 32'h9e03;
  logic [7:0] mm [0:7][0:127]; // Expected contents per bank
  logic [6:0] a_m = 7'h00; // Expected address
  logic [6:0] o_m = 7'h00; // Expected shift offset
  logic [2:0] b_m = 3'h0;
  logic d_m = 1'b1;
  logic s_m = 1'b0;
  dmac_core i_dmac_core (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus_rs_i(rs), .bus_wdata_i(wd),
    .bus_wr_i(wr), .bus_rd_i(rd), .rom_data_i(rom), .bus_rdata_o(rdata), .addr_o(addr),
    .rom_addr_o(rom_addr), .bank_o(bank), .step_dir_o(dir), .shift_en_o(sen),
    .shift_ofs_o(ofs), .last_rs_o(lrs), .last_rnw_o(lrnw));
  dmac_rom_model i_dmac_rom_model (.rom_addr_i(rom_addr), .rom_data_o(rom));
  always #50 sys_clk_i = ~sys_clk_i;
  // Hang guard, far above the eight hundred or so cycles needed
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("Counts: %0d compares, %0d errors", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Read expectation; refused places answer zero
  function automatic logic [7:0] exp_rd(input logic [2:0] b, input logic [6:0] a);
    if (b == DMAC_BANK_FIXED) return {a, 1'b1} ^ 8'hA5;
    if (b > DMAC_BANK_FIXED || ((b == 3'h0 || b == 3'h4) && a >= 7'h50)) return 8'h00;
    return mm[b][a];
  endfunction
  // One strobe, held one cycle, then state compared
  task automatic xfer(input logic r, input logic [1:0] c, input logic [7:0] d);
    @(posedge sys_clk_i);
    rd <= r;
    wr <= !r;
    rs <= c;
    wd <= d;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    wr <= 1'b0;
    #1;
    chk({5'h00, lrnw, lrs}, {5'h00, r, c});
  endtask
  task automatic st();
    chk({1'b0, addr}, {1'b0, a_m});
    chk({dir, sen, 3'h0, bank}, {d_m, s_m, 3'h0, b_m});
    chk({1'b0, ofs}, {1'b0, o_m});
  endtask
  // Read byte stands one cycle, then the bus idles at zero
  task automatic rdchk();
    logic [7:0] e;
    e = exp_rd(b_m, a_m);
    xfer(1'b1, DMAC_RS_DATA, 8'h00);
    chk(rdata, e);
    a_m = d_m ? a_m + 7'h01 : a_m - 7'h01;
    st();
    @(posedge sys_clk_i);
    #1;
    chk(rdata, 8'h00);
  endtask
  task automatic wrd(input logic [7:0] d);
    xfer(1'b0, DMAC_RS_DATA, d);
    if (b_m == 3'h0 && a_m < 7'h50) mm[0][a_m] = d;
    if (b_m inside {[3'h1:3'h4]} && (b_m != 3'h4 || a_m < 7'h50)) mm[b_m][a_m] = d & 8'h1F;
    if (b_m == 3'h0 && s_m && d_m) o_m = (o_m == 7'h4F) ? 7'h00 : o_m + 7'h01;
    if (b_m == 3'h0 && s_m && !d_m) o_m = (o_m == 7'h00) ? 7'h4F : o_m - 7'h01;
    a_m = d_m ? a_m + 7'h01 : a_m - 7'h01;
    st();
  endtask
  task automatic cmd(input logic [1:0] c, input logic [7:0] d);
    xfer(1'b0, c, d);
    if (c == DMAC_RS_CMD && d[7]) a_m = d[6:0];
    if (c == DMAC_RS_CMD && d[7:3] == DMAC_BANK_TAG) b_m = d[2:0];
    if (c == DMAC_RS_DISP && d == DMAC_CMD_HOME) a_m = 7'h00;
    if (c == DMAC_RS_DISP && d == DMAC_CMD_HOME) o_m = 7'h00;
    if (c == DMAC_RS_DISP && d[7:2] == DMAC_ENTRY_TAG) {d_m, s_m} = d[1:0];
    if (c == DMAC_RS_DISP && d == DMAC_CMD_CLEAR) begin
      for (int i = 0; i < DMAC_TXT_DEPTH; i++) mm[0][i] = DMAC_BLANK_CHAR;
    end
    st();
  endtask
  // Writes n random bytes from a, then reads them back
  task automatic burst(input logic [6:0] a, input int n);
    logic [7:0] d;
    cmd(DMAC_RS_CMD, {1'b1, a});
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      if (b_m inside {[3'h1:3'h4]}) d[7:5] = 3'h0;
      wrd(d);
    end
    cmd(DMAC_RS_CMD, {1'b1, a});
    for (int i = 0; i < n; i++) rdchk();
  endtask
  // Host-side clear for a set whose code 20h is not blank
  task automatic alt_clear(input logic [7:0] blank);
    cmd(DMAC_RS_DISP, 8'h20);
    cmd(DMAC_RS_CMD, {DMAC_BANK_TAG, DMAC_BANK_TEXT});
    cmd(DMAC_RS_DISP, {DMAC_ENTRY_TAG, 2'h2});
    cmd(DMAC_RS_CMD, 8'h80);
    for (int i = 0; i < DMAC_TXT_DEPTH; i++) wrd(blank);
    cmd(DMAC_RS_DISP, 8'h24);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk({dir, sen, lrnw, lrs, bank}, 8'h80);
    chk(rdata, 8'h00);
    chk({1'b0, addr}, 8'h00);
    chk({1'b0, ofs}, 8'h00);
    $display("Test reset done");
    cmd(DMAC_RS_DISP, DMAC_CMD_CLEAR);
    for (int m = 0; m < 4; m++) cmd(DMAC_RS_DISP, {DMAC_ENTRY_TAG, m[1:0]});
    cmd(DMAC_RS_DISP, {DMAC_ENTRY_TAG, 2'h2});
    // Every bank code; cursor and blink assumed off by host
    for (int b = 0; b < 8; b++) begin
      cmd(DMAC_RS_CMD, {DMAC_BANK_TAG, b[2:0]});
      burst(7'($random(seed)), 6);
      burst(7'h4E, 4);
    end
    // Reads on setup and display codes answer zero, cursor stays
    for (int c = 0; c < 3; c += 2) begin
      xfer(1'b1, c[1:0], 8'h00);
      chk(rdata, 8'h00);
      st();
    end
    $display("Test banks done");
    cmd(DMAC_RS_CMD, {DMAC_BANK_TAG, DMAC_BANK_TEXT});
    cmd(DMAC_RS_DISP, {DMAC_ENTRY_TAG, 2'h0});
    burst(7'h02, 5);
    cmd(DMAC_RS_CMD, {1'b1, 7'h21});
    cmd(DMAC_RS_DISP, DMAC_CMD_CLEAR);
    for (int i = 0; i < 3; i++) rdchk();
    $display("Test clear done");
    cmd(DMAC_RS_DISP, {DMAC_ENTRY_TAG, 2'h3});
    burst(7'h0A, 3);
    cmd(DMAC_RS_DISP, {DMAC_ENTRY_TAG, 2'h1});
    burst(7'h30, 5);
    cmd(DMAC_RS_CMD, {DMAC_BANK_TAG, DMAC_BANK_ICON});
    burst(7'h05, 2);
    // Host would follow with its register update when idle
    cmd(DMAC_RS_DISP, DMAC_CMD_HOME);
    $display("Test shift and home done");
    alt_clear(8'hA0);
    cmd(DMAC_RS_CMD, {1'b1, 7'h4E});
    for (int i = 0; i < 3; i++) rdchk();
    $display("Test host clear done");
    tally_and_finish();
  end
endmodule
